// *** inc/vd_defines.svh ***
`ifndef VD_DEFINES_SVH
`define VD_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define VD_ROW_W 9
`define VD_COL_W 8
`define VD_DW 8
`define VD_SYNC_N 3

// ----------------------------------------
// Timing, in ns, and cycle conversion
// ----------------------------------------
`define VD_CLK_NS 20
`define VD_CYC_UP(ns) (((ns) + `VD_CLK_NS - 1) / `VD_CLK_NS)
`define VD_CYC_DN(ns) ((ns) / `VD_CLK_NS)
`define VD_T_RAH_NS 10
`define VD_T_CSR_NS 10
`define VD_T_CAC_NS 20
`define VD_T_RAS_NS 60
`define VD_T_RP_NS 55
`define VD_T_REF_NS 8000000
`define VD_REF_ROWS 512
`define VD_REF_PERIOD_CYC `VD_CYC_DN(`VD_T_REF_NS)
`define VD_SH_DIV 4

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define VD_REG_CTRL 8'h00
`define VD_REG_CMD 8'h04
`define VD_REG_SER 8'h08
`define VD_REG_STAT 8'h0c
`define VD_CTRL_REF_EN 0
`define VD_CTRL_REF_ROW 1
`define VD_CTRL_RST 2'h1
`define VD_CMD_OP_LSB 0
`define VD_CMD_ROW_LSB 4
`define VD_CMD_COL_LSB 13
`define VD_CMD_DAT_LSB 21
`define VD_SER_GATE 8

`endif

// *** inc/vd_pkg.sv ***
`include "vd_defines.svh"

package vd_pkg;

  // ----------------------------------------
  // Array operations
  // ----------------------------------------
  typedef enum logic [3:0] {
    VD_OP_NOP,
    VD_OP_RD_XFER,
    VD_OP_SPLIT_RD,
    VD_OP_PSEUDO,
    VD_OP_WR_XFER,
    VD_OP_SPLIT_WR,
    VD_OP_ROW_REF,
    VD_OP_COL_FIRST_REF,
    VD_OP_RAM_RD,
    VD_OP_RAM_WR,
    VD_OP_HIDDEN_REF
  } vd_op_t;

  typedef enum {
    A_IDLE, A_SETUP, A_RAS, A_CAS, A_END, A_HID_UP, A_HID_DN, A_PRECH
  } vd_arr_st_t;

  typedef enum {S_IDLE, S_HI, S_LO} vd_ser_st_t;

  // ----------------------------------------
  // Pin groups
  // ----------------------------------------
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic special_function_select;
    logic transfer_or_drive_n;
    logic [`VD_ROW_W-1:0] addr;
  } vd_ctl_t;

  typedef struct packed {
    logic shift_strobe;
    logic shift_port_gate_n;
  } vd_ser_t;

endpackage

// *** logic/vd_host.sv ***
// Local design decisions: the placing of the registers and the strobed register port.
`include "vd_defines.svh"

// Behaviour
// [R1] Split write: cas high, xfer low, we low, sfs high
// [R2] No shift strobe while write transfer holds row low
// [R3] Split write never changes serial pin direction
// [R4] Pseudo transfer first when serial pin drives out
// [R5] Write-back of read buffer needs pseudo before split write
// [R6] Write-back row msb equals originating read row msb
// [R7] Read transfer puts serial port in read mode
// [R8] Read mode: word driven out after shift edge
// [R9] Read mode gated: pin floats, pointer still advances
// [R10] Serial pointer wraps from 255 to 0
// [R11] Pseudo or write transfer selects write mode
// [R12] Write mode: pin word captured on shift edge
// [R13] Write mode gated: no capture, pointer advances
// [R14] All 512 rows refreshed every 8 ms
// [R15] Any row strobe cycle refreshes its row
// [R16] Row-only refresh: cas and xfer high at fall
// [R17] Cas before row strobe: internal counter refresh
// [R18] Column-first refresh keeps data outputs floating
// [R19] Hidden refresh keeps read data driven
// [R20] Serial buffer needs no refresh
// [R21] Pseudo transfer makes serial pin input, sets start
// [R22] Read transfer: pin drives out at first access
// [R23] Internal refresh counter advances once per refresh
module vd_host #(
  parameter int ROW_W = `VD_ROW_W,
  parameter int COL_W = `VD_COL_W,
  parameter int DW = `VD_DW,
  parameter int SH_DIV = `VD_SH_DIV,
  parameter int REF_PERIOD_CYC = `VD_REF_PERIOD_CYC,
  parameter int REF_ROWS = `VD_REF_ROWS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output vd_pkg::vd_ctl_t ctl,
  output vd_pkg::vd_ser_t ser,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe,
  input wire logic [DW-1:0] sd_in,
  output logic [DW-1:0] sd_out,
  output logic sd_oe
);
  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam logic [3:0] RAH_CYC = 4'(`VD_CYC_UP(`VD_T_RAH_NS));
  localparam logic [3:0] CSR_CYC = 4'(`VD_CYC_UP(`VD_T_CSR_NS));
  // Read data pass the pin synchroniser before sampling
  localparam logic [3:0] CAS_CYC =
    4'(`VD_CYC_UP(`VD_T_CAC_NS) + `VD_SYNC_N);
  localparam logic [3:0] RAS_CYC = 4'(`VD_CYC_UP(`VD_T_RAS_NS));
  localparam logic [3:0] RP_CYC = 4'(`VD_CYC_UP(`VD_T_RP_NS));
  localparam int DVW = $clog2(SH_DIV + 1);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic blocks_serial(vd_pkg::vd_op_t op);
    return op == vd_pkg::VD_OP_PSEUDO || op == vd_pkg::VD_OP_WR_XFER;
  endfunction

  function automatic vd_pkg::vd_ctl_t setup_pins(vd_pkg::vd_op_t op,
                                                 logic [ROW_W-1:0] row);
    vd_pkg::vd_ctl_t p;
    p = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
          special_function_select: 1'b0, transfer_or_drive_n: 1'b1,
          addr: row};
    unique case (op)
      vd_pkg::VD_OP_RD_XFER: p.transfer_or_drive_n = 1'b0;
      vd_pkg::VD_OP_SPLIT_RD: begin
        p.transfer_or_drive_n = 1'b0;
        p.special_function_select = 1'b1;
      end
      vd_pkg::VD_OP_PSEUDO, vd_pkg::VD_OP_WR_XFER: begin
        p.transfer_or_drive_n = 1'b0;
        p.we_n = 1'b0;
      end
      vd_pkg::VD_OP_SPLIT_WR: begin
        p.transfer_or_drive_n = 1'b0; // R1
        p.we_n = 1'b0;
        p.special_function_select = 1'b1;
      end
      vd_pkg::VD_OP_COL_FIRST_REF: p.cas_n = 1'b0; // R17
      default: p.transfer_or_drive_n = 1'b1; // R16
    endcase
    return p;
  endfunction

  function automatic logic [COL_W-1:0] ptr_inc(logic [COL_W-1:0] p);
    return (p == '1) ? '0 : p + 1'b1; // R10
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  vd_pkg::vd_arr_st_t a_st_r, a_st_nxt;
  vd_pkg::vd_ser_st_t s_st_r, s_st_nxt;
  vd_pkg::vd_op_t op_r, op_nxt, cmd_op;
  vd_pkg::vd_ctl_t ctl_r, ctl_nxt;
  vd_pkg::vd_ser_t ser_r, ser_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [ROW_W-1:0] row_r, row_nxt, cmd_row, ref_row;
  logic [COL_W-1:0] col_r, col_nxt, ptr_r, ptr_nxt;
  logic [DW-1:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt;
  logic [DW-1:0] sdat_r, sdat_nxt, srd_r, srd_nxt;
  logic [DW-1:0] dq_out_r, dq_out_nxt, sd_out_r, sd_out_nxt;
  logic dq_oe_r, dq_oe_nxt, sd_oe_r, sd_oe_nxt;
  logic chain_r, chain_nxt, wb_r, wb_nxt, msb_r, msb_nxt;
  logic last_ps_r, last_ps_nxt, wr_mode_r, wr_mode_nxt;
  logic drv_r, drv_nxt, sreq_r, sreq_nxt, sgate_r, sgate_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [DVW-1:0] div_r, div_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [DW-1:0] dq_s1_r, dq_s2_r, dq_s3_r, sd_s1_r, sd_s2_r, sd_s3_r;
  logic ref_req, ref_ack, sh_tick, ser_idle, blk, cmd_go, set_ptr;

  vd_refresh #(
    .PERIOD_CYC(REF_PERIOD_CYC),
    .ROWS(REF_ROWS),
    .ROW_W(ROW_W)
  ) u_refresh (
    .clock(clock),
    .rst(rst),
    .enable(ctrl_r[`VD_CTRL_REF_EN]),
    .ack(ref_ack),
    .req(ref_req),
    .row(ref_row)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    a_st_nxt = a_st_r;
    s_st_nxt = s_st_r;
    op_nxt = op_r;
    ctl_nxt = ctl_r;
    ser_nxt = ser_r;
    cnt_nxt = (cnt_r != 4'h0) ? cnt_r - 4'h1 : cnt_r;
    row_nxt = row_r;
    col_nxt = col_r;
    ptr_nxt = ptr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    sdat_nxt = sdat_r;
    srd_nxt = srd_r;
    dq_out_nxt = dq_out_r;
    sd_out_nxt = sd_out_r;
    dq_oe_nxt = dq_oe_r;
    sd_oe_nxt = sd_oe_r;
    chain_nxt = chain_r;
    wb_nxt = wb_r;
    msb_nxt = msb_r;
    last_ps_nxt = last_ps_r;
    wr_mode_nxt = wr_mode_r;
    drv_nxt = drv_r;
    sreq_nxt = sreq_r;
    sgate_nxt = sgate_r;
    ctrl_nxt = ctrl_r;
    ref_ack = 1'b0;
    set_ptr = 1'b0;
    ser_idle = s_st_r == vd_pkg::S_IDLE && !sreq_r;
    sh_tick = div_r == DVW'(SH_DIV - 1);
    div_nxt = sh_tick ? '0 : div_r + 1'b1;

    // Command decode
    cmd_op = vd_pkg::vd_op_t'(reg_wdata[`VD_CMD_OP_LSB +: 4]);
    cmd_row = reg_wdata[`VD_CMD_ROW_LSB +: ROW_W];
    if (cmd_op == vd_pkg::VD_OP_SPLIT_WR) begin
      if (wb_r) begin
        cmd_row[ROW_W-1] = msb_r; // R6
      end
      if (!wr_mode_r || (wb_r && !last_ps_r)) begin
        cmd_op = vd_pkg::VD_OP_PSEUDO; // R4 R5
      end
    end
    cmd_go = reg_wr && reg_addr == `VD_REG_CMD && a_st_r == vd_pkg::A_IDLE
      && !(ref_req && ctrl_r[`VD_CTRL_REF_EN])
      && cmd_op != vd_pkg::VD_OP_NOP
      && cmd_op <= vd_pkg::VD_OP_HIDDEN_REF
      && (!blocks_serial(cmd_op) || ser_idle); // R2

    if (reg_wr && reg_addr == `VD_REG_CTRL) begin
      ctrl_nxt = reg_wdata[1:0];
    end

    // ----------------------------------------
    // Array sequencer
    // ----------------------------------------
    unique case (a_st_r)
      vd_pkg::A_IDLE: begin
        if (ref_req && ctrl_r[`VD_CTRL_REF_EN]) begin
          ref_ack = 1'b1;
          op_nxt = ctrl_r[`VD_CTRL_REF_ROW] ? vd_pkg::VD_OP_ROW_REF
                                             : vd_pkg::VD_OP_COL_FIRST_REF;
          ctl_nxt = setup_pins(op_nxt, ref_row); // R14 R16 R17
          cnt_nxt = CSR_CYC - 4'h1;
          a_st_nxt = vd_pkg::A_SETUP;
        end else if (cmd_go) begin
          op_nxt = cmd_op;
          chain_nxt = cmd_op != vd_pkg::vd_op_t'(reg_wdata[3:0]);
          row_nxt = cmd_row;
          col_nxt = reg_wdata[`VD_CMD_COL_LSB +: COL_W];
          wdat_nxt = reg_wdata[`VD_CMD_DAT_LSB +: DW];
          ctl_nxt = setup_pins(cmd_op, cmd_row);
          cnt_nxt = CSR_CYC - 4'h1;
          a_st_nxt = vd_pkg::A_SETUP;
        end
      end
      vd_pkg::A_SETUP: begin
        if (cnt_r == 4'h0) begin
          ctl_nxt.ras_n = 1'b0; // R15
          cnt_nxt = RAH_CYC - 4'h1;
          a_st_nxt = vd_pkg::A_RAS;
          unique case (op_r)
            vd_pkg::VD_OP_RD_XFER: begin
              wr_mode_nxt = 1'b0; // R7
              drv_nxt = 1'b0; // R22
              wb_nxt = 1'b1;
              msb_nxt = row_r[ROW_W-1];
              last_ps_nxt = 1'b0;
              set_ptr = 1'b1;
            end
            vd_pkg::VD_OP_SPLIT_RD: begin
              wb_nxt = 1'b1;
              msb_nxt = row_r[ROW_W-1];
              last_ps_nxt = 1'b0;
            end
            vd_pkg::VD_OP_PSEUDO, vd_pkg::VD_OP_WR_XFER: begin
              wr_mode_nxt = 1'b1; // R11 R21
              drv_nxt = 1'b0;
              last_ps_nxt = op_r == vd_pkg::VD_OP_PSEUDO;
              wb_nxt = wb_r && op_r == vd_pkg::VD_OP_PSEUDO;
              set_ptr = 1'b1;
            end
            vd_pkg::VD_OP_SPLIT_WR: begin
              wb_nxt = 1'b0; // R3
              last_ps_nxt = 1'b0;
            end
            default: last_ps_nxt = last_ps_r;
          endcase
        end
      end
      vd_pkg::A_RAS: begin
        if (cnt_r == 4'h0) begin
          if (op_r == vd_pkg::VD_OP_ROW_REF
              || op_r == vd_pkg::VD_OP_COL_FIRST_REF) begin
            cnt_nxt = RAS_CYC - 4'h1; // R18
            a_st_nxt = vd_pkg::A_END;
          end else begin
            ctl_nxt.addr = ROW_W'(col_r);
            ctl_nxt.cas_n = 1'b0;
            if (op_r == vd_pkg::VD_OP_RAM_RD
                || op_r == vd_pkg::VD_OP_HIDDEN_REF) begin
              ctl_nxt.transfer_or_drive_n = 1'b0;
            end
            if (op_r == vd_pkg::VD_OP_RAM_WR) begin
              ctl_nxt.we_n = 1'b0;
              dq_out_nxt = wdat_r;
              dq_oe_nxt = 1'b1;
            end
            cnt_nxt = CAS_CYC - 4'h1;
            a_st_nxt = vd_pkg::A_CAS;
          end
        end
      end
      vd_pkg::A_CAS: begin
        if (cnt_r == 4'h0) begin
          rdat_nxt = dq_s3_r;
          cnt_nxt = RAS_CYC - 4'h1;
          a_st_nxt = vd_pkg::A_END;
          if (op_r == vd_pkg::VD_OP_RD_XFER) begin
            ctl_nxt.transfer_or_drive_n = 1'b1;
          end
          if (op_r == vd_pkg::VD_OP_HIDDEN_REF) begin
            ctl_nxt.ras_n = 1'b1; // R19
            cnt_nxt = RP_CYC - 4'h1;
            a_st_nxt = vd_pkg::A_HID_UP;
          end
        end
      end
      vd_pkg::A_HID_UP: begin
        if (cnt_r == 4'h0) begin
          ctl_nxt.ras_n = 1'b0; // R17 R19
          cnt_nxt = RAS_CYC - 4'h1;
          a_st_nxt = vd_pkg::A_HID_DN;
        end
      end
      vd_pkg::A_HID_DN: begin
        if (cnt_r == 4'h0) begin
          a_st_nxt = vd_pkg::A_END;
        end
      end
      vd_pkg::A_END: begin
        if (cnt_r == 4'h0) begin
          ctl_nxt = setup_pins(vd_pkg::VD_OP_NOP, ctl_r.addr);
          dq_oe_nxt = 1'b0;
          cnt_nxt = RP_CYC - 4'h1;
          a_st_nxt = vd_pkg::A_PRECH;
        end
      end
      vd_pkg::A_PRECH: begin
        if (cnt_r == 4'h0) begin
          a_st_nxt = vd_pkg::A_IDLE;
          if (chain_r) begin
            // Inserted pseudo done, now the requested split write
            chain_nxt = 1'b0;
            op_nxt = vd_pkg::VD_OP_SPLIT_WR;
            ctl_nxt = setup_pins(vd_pkg::VD_OP_SPLIT_WR, row_r);
            cnt_nxt = CSR_CYC - 4'h1;
            a_st_nxt = vd_pkg::A_SETUP;
          end
        end
      end
    endcase

    // ----------------------------------------
    // Serial port
    // ----------------------------------------
    blk = a_st_nxt != vd_pkg::A_IDLE && blocks_serial(op_nxt); // R2
    if (reg_wr && reg_addr == `VD_REG_SER && ser_idle) begin
      sreq_nxt = 1'b1;
      sdat_nxt = reg_wdata[DW-1:0];
      sgate_nxt = reg_wdata[`VD_SER_GATE];
    end
    unique case (s_st_r)
      vd_pkg::S_IDLE: begin
        ser_nxt.shift_port_gate_n = !(blk && op_nxt == vd_pkg::VD_OP_WR_XFER);
        if (sreq_r && sh_tick && !blk) begin
          sreq_nxt = 1'b0;
          ser_nxt.shift_strobe = 1'b1;
          ser_nxt.shift_port_gate_n = sgate_r;
          if (wr_mode_r && !sgate_r) begin
            sd_out_nxt = sdat_r; // R12
            sd_oe_nxt = 1'b1;
          end
          if (!wr_mode_r) begin
            drv_nxt = !sgate_r; // R8 R9 R22
          end
          s_st_nxt = vd_pkg::S_HI;
        end
      end
      vd_pkg::S_HI: begin
        if (sh_tick) begin
          if (!wr_mode_r && !sgate_r) begin
            srd_nxt = sd_s3_r; // R8
          end
          ser_nxt.shift_strobe = 1'b0;
          ptr_nxt = ptr_inc(ptr_r); // R9 R13
          s_st_nxt = vd_pkg::S_LO;
        end
      end
      vd_pkg::S_LO: begin
        if (sh_tick) begin
          sd_oe_nxt = 1'b0;
          ser_nxt.shift_port_gate_n = 1'b1;
          s_st_nxt = vd_pkg::S_IDLE;
        end
      end
    endcase
    if (set_ptr) begin
      ptr_nxt = col_r; // R21
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    rdata_nxt = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        `VD_REG_CTRL: rdata_nxt = {30'h0, ctrl_r};
        `VD_REG_CMD: rdata_nxt = 32'({row_r, op_r});
        `VD_REG_SER: rdata_nxt = 32'(srd_r);
        `VD_REG_STAT: rdata_nxt = {8'h0, 8'(rdat_r), 8'(ptr_r),
          2'h0, wb_r, ref_req, drv_r, wr_mode_r, !ser_idle,
          a_st_r != vd_pkg::A_IDLE};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      a_st_r <= vd_pkg::A_IDLE;
      s_st_r <= vd_pkg::S_IDLE;
      op_r <= vd_pkg::VD_OP_NOP;
      ctl_r <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                 special_function_select: 1'b0,
                 transfer_or_drive_n: 1'b1, addr: '0};
      ser_r <= '{shift_strobe: 1'b0, shift_port_gate_n: 1'b1};
      cnt_r <= 4'h0;
      {row_r, col_r, ptr_r} <= '0;
      {wdat_r, rdat_r, sdat_r, srd_r, dq_out_r, sd_out_r} <= '0;
      {dq_oe_r, sd_oe_r, chain_r, wb_r, msb_r, last_ps_r} <= '0;
      {wr_mode_r, drv_r, sreq_r, sgate_r} <= '0;
      ctrl_r <= `VD_CTRL_RST;
      div_r <= '0;
      rdata_r <= 32'h0;
      {dq_s1_r, dq_s2_r, dq_s3_r, sd_s1_r, sd_s2_r, sd_s3_r} <= '0;
    end else begin
      a_st_r <= a_st_nxt;
      s_st_r <= s_st_nxt;
      op_r <= op_nxt;
      ctl_r <= ctl_nxt;
      ser_r <= ser_nxt;
      cnt_r <= cnt_nxt;
      {row_r, col_r, ptr_r} <= {row_nxt, col_nxt, ptr_nxt};
      {wdat_r, rdat_r, sdat_r, srd_r} <= {wdat_nxt, rdat_nxt, sdat_nxt,
                                          srd_nxt};
      {dq_out_r, sd_out_r} <= {dq_out_nxt, sd_out_nxt};
      {dq_oe_r, sd_oe_r, chain_r, wb_r, msb_r, last_ps_r} <=
        {dq_oe_nxt, sd_oe_nxt, chain_nxt, wb_nxt, msb_nxt, last_ps_nxt};
      {wr_mode_r, drv_r, sreq_r, sgate_r} <=
        {wr_mode_nxt, drv_nxt, sreq_nxt, sgate_nxt};
      ctrl_r <= ctrl_nxt;
      div_r <= div_nxt;
      rdata_r <= rdata_nxt;
      // Pin synchronisers, third stage is the only consumer
      {dq_s1_r, dq_s2_r, dq_s3_r} <= {dq_in, dq_s1_r, dq_s2_r};
      {sd_s1_r, sd_s2_r, sd_s3_r} <= {sd_in, sd_s1_r, sd_s2_r};
    end
  end

  assign reg_rdata = rdata_r;
  assign ctl = ctl_r;
  assign ser = ser_r;
  assign dq_out = dq_out_r;
  assign dq_oe = dq_oe_r;
  assign sd_out = sd_out_r;
  assign sd_oe = sd_oe_r;
endmodule

// *** logic/vd_refresh.sv ***
`include "vd_defines.svh"

// Paces refreshes evenly and owes up to 15 missed ones until served or until disabled.
module vd_refresh #(
  parameter int PERIOD_CYC = `VD_REF_PERIOD_CYC,
  parameter int ROWS = `VD_REF_ROWS,
  parameter int ROW_W = `VD_ROW_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic ack,
  output logic req,
  output logic [ROW_W-1:0] row
);
  localparam int INT_CYC = (PERIOD_CYC / ROWS < 1) ? 1 : PERIOD_CYC / ROWS;
  localparam int TW = $clog2(INT_CYC + 1);

  logic [TW-1:0] tmr_r, tmr_nxt;
  logic [3:0] debt_r, debt_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  logic tick;

  always_comb begin
    tick = enable && (tmr_r == TW'(INT_CYC - 1));
    tmr_nxt = (tick || !enable) ? '0 : tmr_r + 1'b1;
    debt_nxt = debt_r;
    // Debt counter: a new interval and a served one cancel out
    if (!enable) begin
      debt_nxt = '0;
    end else if (tick && !ack && debt_r != 4'hf) begin
      debt_nxt = debt_r + 4'h1; // R14
    end else if (!tick && ack && debt_r != 4'h0) begin
      debt_nxt = debt_r - 4'h1;
    end
    row_nxt = row_r;
    if (ack) begin
      row_nxt = (row_r == ROW_W'(ROWS - 1)) ? '0 : row_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tmr_r <= '0;
      debt_r <= 4'h0;
      row_r <= '0;
    end else begin
      tmr_r <= tmr_nxt;
      debt_r <= debt_nxt;
      row_r <= row_nxt;
    end
  end

  assign req = debt_r != 4'h0;
  assign row = row_r;
endmodule

// *** sim/vd_host_chk.sv ***
// --------------------
// Pin protocol checks
// --------------------
module vd_host_chk #(
  parameter int SH_DIV = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire vd_pkg::vd_ctl_t ctl,
  input wire vd_pkg::vd_ser_t ser,
  input wire logic dq_oe,
  input wire logic sd_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  int sh_cnt_r;
  int sh_cnt_nxt;
  always_comb sh_cnt_nxt = ser.shift_strobe ? sh_cnt_r + 1 : 0;
  always_ff @(posedge clock) sh_cnt_r <= rst ? 0 : sh_cnt_nxt;
  property p_rst;
    disable iff (1'b0) rst |=> ctl.ras_n && ctl.cas_n && !ser.shift_strobe
      && ser.shift_port_gate_n && !dq_oe && !sd_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  property p_ras_len;
    $fell(ctl.ras_n) |-> ##[3:9] $rose(ctl.ras_n);
  endproperty
  a_ras_len: assert property (p_ras_len) else $error("ras pulse");
  property p_cfr;
    $fell(ctl.ras_n) && !ctl.cas_n |-> !$past(ctl.cas_n);
  endproperty
  a_cfr: assert property (p_cfr) else $error("cas not first");
  property p_cfr_dq;
    $fell(ctl.ras_n) && !ctl.cas_n |-> !dq_oe [*3];
  endproperty
  a_cfr_dq: assert property (p_cfr_dq) else $error("dq driven");
  // Serial access is blocked while a pseudo or write transfer holds ras
  property p_no_sh;
    $fell(ctl.ras_n) && ctl.cas_n && !ctl.transfer_or_drive_n && !ctl.we_n
      && !ctl.special_function_select
      |-> !$rose(ser.shift_strobe) until ctl.ras_n;
  endproperty
  a_no_sh: assert property (p_no_sh) else $error("shift in xfer");
  property p_sh_len;
    $fell(ser.shift_strobe) |-> sh_cnt_r == SH_DIV;
  endproperty
  a_sh_len: assert property (p_sh_len) else $error("shift width");
  property p_gate;
    ser.shift_strobe && $past(ser.shift_strobe)
      |-> $stable(ser.shift_port_gate_n);
  endproperty
  a_gate: assert property (p_gate) else $error("gate moved");
  property p_sd_oe;
    sd_oe |-> !ser.shift_port_gate_n;
  endproperty
  a_sd_oe: assert property (p_sd_oe) else $error("masked drive");
endmodule

bind vd_host vd_host_chk #(.SH_DIV(SH_DIV)) u_chk (
  .clock(clock), .rst(rst), .ctl(ctl), .ser(ser), .dq_oe(dq_oe),
  .sd_oe(sd_oe)
);

// *** sim/vd_vram.sv ***
// --------------------
// Device model
// --------------------
module vd_vram (
  input wire logic clock,
  input wire vd_pkg::vd_ctl_t ctl,
  input wire vd_pkg::vd_ser_t ser,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic [7:0] sd_out,
  input wire logic sd_oe,
  output logic [7:0] dq_w,
  output logic [7:0] sd_w,
  output logic [3:0] kind
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [512][256];
  logic [7:0] sbuf [256];
  logic [7:0] ptr, col, sq, dq_l, sd_l;
  logic [8:0] row, sw_row, ref_row;
  logic wr_mode, drive, xfer;
  int n_ref;
  initial begin
    mem = '{default: 8'h00};
    sbuf = '{default: 8'h00};
    {kind, wr_mode, drive, xfer, dq_l, sd_l, ref_row, ptr} = 40'h0;
    n_ref = 0;
  end
  // Pins settle together; look just after the strobe edge
  always @(negedge ctl.ras_n) begin
    #1;
    row = ctl.addr;
    xfer = ctl.cas_n && !ctl.transfer_or_drive_n;
    if (!ctl.cas_n) begin
      if (kind == 4'h8 && !ctl.transfer_or_drive_n) kind = 4'ha;
      else kind = 4'h7;
      ref_row = ref_row + 9'h1;
      n_ref++;
    end else if (!xfer) begin
      kind = 4'h6;
    end else if (ctl.we_n) begin
      kind = ctl.special_function_select ? 4'h2 : 4'h1;
      if (kind == 4'h1) wr_mode = 1'b0;
      for (int i = 0; i < 256; i++)
        if (kind == 4'h1 || i[7] != ptr[7]) sbuf[i] = mem[row][i];
    end else if (ctl.special_function_select) begin
      kind = 4'h5;
      sw_row = row;
    end else begin
      kind = ser.shift_port_gate_n ? 4'h3 : 4'h4;
      wr_mode = 1'b1;
      drive = 1'b0;
      if (kind == 4'h4)
        for (int i = 0; i < 256; i++) mem[row][i] = sbuf[i];
    end
  end
  always @(negedge ctl.cas_n) begin
    #1;
    col = ctl.addr[7:0];
    if (ctl.ras_n) kind = 4'h7;
    else if (xfer) ptr = col;
    else begin
      kind = ctl.we_n ? 4'h8 : 4'h9;
      if (!ctl.we_n) mem[row][col] = dq_w;
    end
  end
  always @(posedge ser.shift_strobe) begin
    #1;
    if (!wr_mode) begin
      drive = 1'b1;
      sq = sbuf[ptr];
    end else if (!ser.shift_port_gate_n) begin
      sbuf[ptr] = sd_w;
    end
    ptr = ptr + 8'h1;
  end
  // Released lines flip, so a stale level can never pass as data
  always @(posedge clock) begin
    dq_l <= dq_w;
    sd_l <= sd_w;
  end
  assign dq_w = dq_oe ? dq_out : (!ctl.cas_n && !ctl.transfer_or_drive_n
    && ctl.we_n && !xfer) ? mem[row][col] : ~dq_l;
  assign sd_w = sd_oe ? sd_out : (drive && !wr_mode
    && !ser.shift_port_gate_n) ? sq : ~sd_l;
endmodule

// *** sim/video_dram_serial_port_refresh_tb.sv ***
module video_dram_serial_port_refresh_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [3:0] op;
    logic [8:0] row;
    logic [7:0] col;
    logic [7:0] dat;
    logic wm;
  } vd_row_t;
  localparam int REF_CYC = 10240;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, st;
  vd_pkg::vd_ctl_t ctl;
  vd_pkg::vd_ser_t ser;
  logic [7:0] dq_out, dq_w, sd_out, sd_w, p;
  logic dq_oe, sd_oe;
  logic [3:0] kind;
  int n_fail = 0;
  int num_checks = 0;
  int n0;
  vd_row_t tab [8] = '{
    '{4'h9, 9'h003, 8'h07, 8'h5a, 1'b0},
    '{4'h8, 9'h003, 8'h07, 8'h5a, 1'b0},
    '{4'ha, 9'h003, 8'h07, 8'h5a, 1'b0},
    '{4'h6, 9'h008, 8'h00, 8'h00, 1'b0},
    '{4'h7, 9'h000, 8'h00, 8'h00, 1'b0},
    '{4'h2, 9'h002, 8'h80, 8'h00, 1'b0},
    '{4'h3, 9'h004, 8'h00, 8'h00, 1'b1},
    '{4'h5, 9'h004, 8'h00, 8'h00, 1'b1}
  };
  logic [7:0] exp_rd [3] = '{8'ha1, 8'h00, 8'hc3};
  always #10 clock = ~clock;
  vd_host #(
    .REF_PERIOD_CYC(REF_CYC),
    .REF_ROWS(512)
  ) dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctl(ctl),
    .ser(ser), .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe),
    .sd_in(sd_w), .sd_out(sd_out), .sd_oe(sd_oe)
  );
  vd_vram dev (
    .clock(clock), .ctl(ctl), .ser(ser), .dq_out(dq_out), .dq_oe(dq_oe),
    .sd_out(sd_out), .sd_oe(sd_oe), .dq_w(dq_w), .sd_w(sd_w), .kind(kind)
  );
  // --------------------
  // Bus tasks
  // --------------------
  task automatic chk(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Refused requests leave no trace but busy, so poll until both clear
  task automatic wait_idle;
    for (int i = 0; i < 300; i++) begin
      rd(8'h0c, st);
      if (st[1:0] === 2'b00) return;
    end
    chk("idle", 32'h0, 32'h1);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [8:0] r,
                     input logic [7:0] c);
    wr(8'h04, {11'h0, c, r, op});
    wait_idle();
  endtask
  task automatic sacc(input logic g, input logic [7:0] d);
    wr(8'h08, {23'h0, g, d});
    wait_idle();
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    report_and_stop();
  end
  // --------------------
  // Scenarios
  // --------------------
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(8'h00, st);
    chk("ctrl", 32'h1, st);
    chk("ras_n", 1'b1, ctl.ras_n);
    wr(8'h00, 32'h0);
    foreach (tab[i]) begin
      wr(8'h04, {3'h0, tab[i].dat, tab[i].col, tab[i].row, tab[i].op});
      wait_idle();
      chk("kind", tab[i].op, kind);
      chk("wmode", tab[i].wm, st[2]);
      if (tab[i].op inside {4'h8, 4'ha}) begin
        chk("rdat", tab[i].dat, st[23:16]);
      end
    end
    cmd(4'h3, 9'h000, 8'hfe);
    chk("ptr", 8'hfe, dev.ptr);
    chk("drive", 1'b0, dev.drive);
    sacc(1'b0, 8'ha1);
    sacc(1'b1, 8'hb2);
    sacc(1'b0, 8'hc3);
    cmd(4'h4, 9'h106, 8'h00);
    chk("kind", 4'h4, kind);
    n0 = dev.n_ref;
    wr(8'h00, 32'h1);
    repeat (REF_CYC + 100) @(posedge clock);
    chk("refs", 1'b1, dev.n_ref - n0 >= 512);
    wr(8'h00, 32'h3);
    repeat (100) @(posedge clock);
    chk("rowref", 4'h6, kind);
    wr(8'h00, 32'h0);
    wait_idle();
    cmd(4'h1, 9'h106, 8'hfe);
    chk("wmode", 1'b0, st[2]);
    chk("drive", 1'b0, dev.drive);
    foreach (exp_rd[i]) begin
      sacc(1'b0, 8'h00);
      rd(8'h08, st);
      chk("sword", exp_rd[i], st[7:0]);
    end
    chk("drive", 1'b1, dev.drive);
    p = dev.ptr;
    sacc(1'b1, 8'h00);
    rd(8'h0c, st);
    chk("ptr", p + 8'h1, st[15:8]);
    chk("ptr", p + 8'h1, dev.ptr);
    cmd(4'h5, 9'h004, 8'h00);
    chk("kind", 4'h5, kind);
    chk("msb", 1'b1, dev.sw_row[8]);
    chk("drive", 1'b0, dev.drive);
    chk("wmode", 1'b1, st[2]);
    chk("wb", 1'b0, st[5]);
    report_and_stop();
  end
endmodule
